/* rtl/pbw_device.sv */
// Pack controller device end: balance gating, watchdog, FET and pin control.
//
// Added by the designer: the APB slave port, on the host end.
`timescale 1ns/1ps
`include "pbw_cfg.svh"
module pbw_device
    import pbw_pkg::*;
#(
    parameter int WDT_TIMEOUT_MS = `PBW_WDT_TIMEOUT_MS,
    parameter int FET_OFF_CYC = `PBW_FET_OFF_PULSE_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Link to the host.
    pbw_link_if.dev link,
    // Measurement and fault status.
    input wire logic charging_current_flag_i,
    input wire logic discharging_current_flag_i,
    input wire logic [11:0] cell_v_i [8],
    input wire logic [7:0] cell_balance_req_i,
    input wire logic [4:0] pack_fault_i,
    input wire logic overvoltage_lockout_i,
    input wire logic cell_differential_fault_i,
    input wire logic open_wire_i,
    // Gate and balance outputs.
    output logic [7:0] balance_out_o,
    output logic [2:0] fet_gate_o,
    output logic [2:0] fet_pulldown_o
);
    // ------------------------------------------------------------------
    // Registers written over the link.
    // ------------------------------------------------------------------
    logic [7:0] bal_sel_reg;   // Balance output select.
    logic [6:0] ctrl_reg;      // Host control bits.
    logic [4:0] cfg_reg;       // Balance and fuse options.
    logic [2:0] fet_req_reg;   // Host FET requests: charge, discharge, precharge.
    pbw_time_s on_time_reg;    // Balance on duration.
    pbw_time_s off_time_reg;   // Balance off duration.
    logic [11:0] eoc_thr_reg;  // End-of-charge threshold.
    logic wr_hit;              // A write is present this cycle.
    logic wdt_to_reg;          // Watchdog timed out.
    logic resume;              // Traffic returns after a timeout.

    assign wr_hit = link.wr_valid;
    assign resume = link.addr_seen & wdt_to_reg;

    // Data registers take link writes at their offsets.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bal_sel_reg <= 8'h00;
            cfg_reg <= 5'h00;
            fet_req_reg <= 3'h0;
            on_time_reg <= '0;
            off_time_reg <= '0;
            eoc_thr_reg <= 12'hFFF;
        end else if (wr_hit) begin
            case (link.wr_addr)
                `PBW_REG_BAL_SEL: bal_sel_reg <= link.wr_data;
                `PBW_REG_CFG: cfg_reg <= link.wr_data[4:0];
                `PBW_REG_FET_REQ: fet_req_reg <= link.wr_data[2:0];
                `PBW_REG_ON_LO: on_time_reg.count[7:0] <= link.wr_data;
                `PBW_REG_ON_HI: begin
                    on_time_reg.count[9:8] <= link.wr_data[1:0];
                    on_time_reg.scale <= link.wr_data[5:4];
                end
                `PBW_REG_OFF_LO: off_time_reg.count[7:0] <= link.wr_data;
                `PBW_REG_OFF_HI: begin
                    off_time_reg.count[9:8] <= link.wr_data[1:0];
                    off_time_reg.scale <= link.wr_data[5:4];
                end
                `PBW_REG_EOC_LO: eoc_thr_reg[7:0] <= link.wr_data;
                `PBW_REG_EOC_HI: eoc_thr_reg[11:8] <= link.wr_data[3:0];
                default: begin
                end
            endcase
        end
    end

    // Control bits; a write in the resume cycle wins over the clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= 7'h00;
        end else if (wr_hit && link.wr_addr == `PBW_REG_CTRL) begin
            ctrl_reg <= link.wr_data[6:0];
        end else if (resume) begin
            ctrl_reg <= ctrl_reg & `PBW_CTRL_RESUME_KEEP;
        end
    end

    // ------------------------------------------------------------------
    // Time base: microsecond, millisecond, second and minute ticks.
    // ------------------------------------------------------------------
    logic [4:0] us_cnt_reg;
    logic [9:0] ms_cnt_reg;
    logic [9:0] s_cnt_reg;
    logic [5:0] min_cnt_reg;
    logic us_tick, ms_tick, s_tick, min_tick;

    assign us_tick = us_cnt_reg == 5'(`PBW_US_CYC - 1);
    assign ms_tick = us_tick && ms_cnt_reg == 10'(`PBW_UNITS_PER_MS - 1);
    assign s_tick = ms_tick && s_cnt_reg == 10'(`PBW_UNITS_PER_S - 1);
    assign min_tick = s_tick && min_cnt_reg == 6'(`PBW_S_PER_MIN - 1);

    // Chained prescalers, each wraps on its own tick.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            us_cnt_reg <= 5'h00;
            ms_cnt_reg <= 10'h000;
            s_cnt_reg <= 10'h000;
            min_cnt_reg <= 6'h00;
        end else begin
            us_cnt_reg <= us_tick ? 5'h00 : us_cnt_reg + 5'h01;
            if (us_tick) ms_cnt_reg <= ms_tick ? 10'h000 : ms_cnt_reg + 10'h001;
            if (ms_tick) s_cnt_reg <= s_tick ? 10'h000 : s_cnt_reg + 10'h001;
            if (s_tick) min_cnt_reg <= min_tick ? 6'h00 : min_cnt_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog.
    // ------------------------------------------------------------------
    logic wdt_active;
    logic [15:0] wdt_cnt_reg;
    logic int_low_reg;
    logic serial_reset_reg;

    assign wdt_active = |ctrl_reg[`PBW_CTRL_NVM:`PBW_CTRL_SCAN];

    // Counts whole milliseconds without traffic; restarts on an address.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !wdt_active || link.addr_seen) begin
            wdt_cnt_reg <= 16'h0000;
        end else if (ms_tick && !wdt_to_reg) begin
            wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
        end
    end

    // Timeout holds until a start and valid address are seen.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || link.addr_seen) begin
            wdt_to_reg <= 1'b0;
        end else if (wdt_active && ms_tick && wdt_cnt_reg == 16'(WDT_TIMEOUT_MS - 1)) begin
            wdt_to_reg <= 1'b1;
        end
    end

    // Serial reset pulse at timeout; interrupt low for one ms each second.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            serial_reset_reg <= 1'b0;
            int_low_reg <= 1'b0;
        end else begin
            serial_reset_reg <= wdt_active && ms_tick && !wdt_to_reg && !link.addr_seen
                && wdt_cnt_reg == 16'(WDT_TIMEOUT_MS - 1);
            // A second tick is also a millisecond tick, so the set must win over the clear.
            if (!wdt_to_reg || link.addr_seen) begin
                int_low_reg <= 1'b0;
            end else if (s_tick || serial_reset_reg) begin
                int_low_reg <= 1'b1;
            end else if (ms_tick) begin
                int_low_reg <= 1'b0;
            end
        end
    end

    assign link.serial_reset = serial_reset_reg;
    assign link.int_n = ~int_low_reg;

    // ------------------------------------------------------------------
    // End-of-charge and fault pins.
    // ------------------------------------------------------------------
    logic all_above, all_below;
    logic eoc_low_reg, sd_low_reg, fuse_reg;

    // Compares every cell against the threshold.
    always_comb begin
        all_above = 1'b1;
        all_below = 1'b1;
        for (int i = 0; i < 8; i++) begin
            all_above = all_above & (cell_v_i[i] > eoc_thr_reg);
            all_below = all_below & (cell_v_i[i] < eoc_thr_reg);
        end
    end

    // Pin states with hysteresis on end-of-charge.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            eoc_low_reg <= 1'b0;
            sd_low_reg <= 1'b0;
            fuse_reg <= 1'b0;
        end else begin
            if (all_above) eoc_low_reg <= 1'b1;
            else if (all_below) eoc_low_reg <= 1'b0;
            sd_low_reg <= |pack_fault_i;
            fuse_reg <= overvoltage_lockout_i
                | (cfg_reg[`PBW_CFG_FUSE_DIFF] & cell_differential_fault_i)
                | (cfg_reg[`PBW_CFG_FUSE_OPEN] & open_wire_i);
        end
    end

    assign link.sd_o = 1'b0;
    assign link.sd_oe = sd_low_reg;
    assign link.eoc_o = 1'b0;
    assign link.eoc_oe = eoc_low_reg;
    assign link.fuse_drive = fuse_reg;

    // ------------------------------------------------------------------
    // Balance enable and on/off timer.
    // ------------------------------------------------------------------
    logic bal_en;
    logic forced_off;
    pbw_phase_e phase_reg;
    logic [9:0] unit_cnt_reg;
    logic [1:0] cur_scale;
    logic unit_tick;
    logic [7:0] bal_next;

    assign forced_off = link.fets_off_a | wdt_to_reg;
    assign bal_en = (cfg_reg[`PBW_CFG_IN_CHG] & charging_current_flag_i
            & ~discharging_current_flag_i)
        | (cfg_reg[`PBW_CFG_IN_DCHG] & discharging_current_flag_i
            & ~charging_current_flag_i)
        | (cfg_reg[`PBW_CFG_AT_EOC] & eoc_low_reg);
    assign cur_scale = (phase_reg == PBW_PH_ON) ? on_time_reg.scale : off_time_reg.scale;

    // Picks the tick matching the running phase's scale.
    always_comb begin
        case (cur_scale)
            `PBW_SCALE_US: unit_tick = us_tick;
            `PBW_SCALE_MS: unit_tick = ms_tick;
            `PBW_SCALE_S: unit_tick = s_tick;
            `PBW_SCALE_MIN: unit_tick = min_tick;
            default: unit_tick = 1'b0;
        endcase
    end

    // Counts units down and swaps phase at zero.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_reg <= PBW_PH_ON;
            unit_cnt_reg <= 10'h000;
        end else if (unit_tick) begin
            if (unit_cnt_reg != 10'h000) begin
                unit_cnt_reg <= unit_cnt_reg - 10'h001;
            end else if (phase_reg == PBW_PH_ON) begin
                phase_reg <= PBW_PH_OFF;
                unit_cnt_reg <= off_time_reg.count;
            end else begin
                phase_reg <= PBW_PH_ON;
                unit_cnt_reg <= on_time_reg.count;
            end
        end
    end

    // Host override, else automatic balancing in the on phase only.
    always_comb begin
        if (forced_off) begin
            bal_next = 8'h00;
        end else if (ctrl_reg[`PBW_CTRL_BAL]) begin
            bal_next = ctrl_reg[`PBW_CTRL_BAL_ON] ? bal_sel_reg : 8'h00;
        end else if (phase_reg == PBW_PH_ON && bal_en) begin
            bal_next = cell_balance_req_i;
        end else begin
            bal_next = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) balance_out_o <= 8'h00;
        else balance_out_o <= bal_next;
    end

    // ------------------------------------------------------------------
    // Power FETs with timed turn-off pull-down.
    // ------------------------------------------------------------------
    logic [2:0] fet_next;
    logic [12:0] pd_cnt_reg [3];

    assign fet_next = forced_off ? 3'h0
        : ctrl_reg[`PBW_CTRL_FET] ? fet_req_reg : {3{~sd_low_reg}};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) fet_gate_o <= 3'h0;
        else fet_gate_o <= fet_next;
    end

    for (genvar g = 0; g < 3; g++) begin : g_pd
        // Loads the pulse length on each on-to-off edge of the gate.
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                pd_cnt_reg[g] <= 13'h0000;
                fet_pulldown_o[g] <= 1'b0;
            end else begin
                if (fet_gate_o[g] && !fet_next[g]) pd_cnt_reg[g] <= 13'(FET_OFF_CYC);
                else if (pd_cnt_reg[g] != 13'h0000) pd_cnt_reg[g] <= pd_cnt_reg[g] - 13'h0001;
                fet_pulldown_o[g] <= (fet_gate_o[g] && !fet_next[g])
                    || pd_cnt_reg[g] > 13'h0001;
            end
        end
    end
endmodule

/* rtl/pbw_cfg.svh */
// Shared constants for the pack balance and watchdog control pair.
//Contract
//- Balance enable follows direction options, end-of-charge exception
//- On/off times: two-bit scale, ten-bit count
//- Balance only in on phase, off in off phase
//- Host balance bit suspends automatic balancing
//- Select register bits map to balance outputs
//- Outputs-on bit drives selected balance outputs
//- Watchdog active only when any host bit set
//- No traffic for timeout period raises timeout
//- Start plus valid address restarts the watchdog
//- Timeout: outputs off, serial reset, interrupt pulses
//- FETs stay forced off until traffic returns
//- Resume clears host bits except balance control
//- FET turn-off pull-down is a timed pulse
//- Shutdown low while any fault exists
//- End-of-charge low above threshold, high below
//- Fuse drive high on overvoltage lockout
//- Fuse drive optionally on differential or open-wire
//- FETs-off input forces every FET off
`ifndef PBW_CFG_SVH
`define PBW_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------------
`define PBW_CLK_HZ 20000000
`define PBW_US_CYC (`PBW_CLK_HZ / 1000000)
`define PBW_UNITS_PER_MS 1000
`define PBW_UNITS_PER_S 1000
`define PBW_S_PER_MIN 60
`define PBW_FET_OFF_PULSE_US 300
`define PBW_FET_OFF_PULSE_CYC ((`PBW_FET_OFF_PULSE_US * `PBW_CLK_HZ) / 1000000)
`define PBW_WDT_TIMEOUT_MS 1000

// ----------------------------------------------------------------------
// Device register offsets on the link.
// ----------------------------------------------------------------------
`define PBW_REG_BAL_SEL 8'h84
`define PBW_REG_CTRL 8'h85
`define PBW_REG_CFG 8'h86
`define PBW_REG_FET_REQ 8'h87
`define PBW_REG_ON_LO 8'h88
`define PBW_REG_ON_HI 8'h89
`define PBW_REG_OFF_LO 8'h8A
`define PBW_REG_OFF_HI 8'h8B
`define PBW_REG_EOC_LO 8'h8C
`define PBW_REG_EOC_HI 8'h8D

// Control register bits.
`define PBW_CTRL_SCAN 0
`define PBW_CTRL_CMON 1
`define PBW_CTRL_LMON 2
`define PBW_CTRL_BAL 3
`define PBW_CTRL_FET 4
`define PBW_CTRL_NVM 5
`define PBW_CTRL_BAL_ON 6
`define PBW_CTRL_RESUME_KEEP 7'h48

// Configuration register bits.
`define PBW_CFG_IN_CHG 0
`define PBW_CFG_IN_DCHG 1
`define PBW_CFG_AT_EOC 2
`define PBW_CFG_FUSE_DIFF 3
`define PBW_CFG_FUSE_OPEN 4

// Time scale codes.
`define PBW_SCALE_US 2'h0
`define PBW_SCALE_MS 2'h1
`define PBW_SCALE_S 2'h2
`define PBW_SCALE_MIN 2'h3

// ----------------------------------------------------------------------
// Host APB register offsets.
// ----------------------------------------------------------------------
`define PBW_APB_LINK_WR 8'h00
`define PBW_APB_PING 8'h04
`define PBW_APB_PIN_CTRL 8'h08
`define PBW_APB_STATUS 8'h0C
`define PBW_APB_IRQ_STAT 8'h10
`define PBW_APB_IRQ_CLR 8'h14
`define PBW_APB_IRQ_EN 8'h18
`define PBW_IRQ_W 5

`endif

/* rtl/pbw_pkg.sv */
// Types shared by both ends of the pack balance and watchdog link.
package pbw_pkg;
    // Balance timer phase.
    typedef enum logic {PBW_PH_ON, PBW_PH_OFF} pbw_phase_e;
    // One on or off duration: scale code over a ten-bit count.
    typedef struct packed {
        logic [1:0] scale;
        logic [9:0] count;
    } pbw_time_s;
endpackage

/* rtl/pbw_link_if.sv */
// Link between the pack controller device and its host controller.
`timescale 1ns/1ps
interface pbw_link_if;
    logic addr_seen;       // Start plus valid slave address seen, pulse.
    logic wr_valid;        // Register write, pulse.
    logic [7:0] wr_addr;   // Register offset of the write.
    logic [7:0] wr_data;   // Register data of the write.
    logic fets_off_a;      // Force all FETs off, level, active high.
    logic int_n;           // Interrupt, active low.
    logic serial_reset;    // Serial interface reset, pulse.
    logic fuse_drive;      // Fuse drive, active high.
    logic sd_o;            // Shutdown open-drain output value.
    logic sd_oe;           // Shutdown open-drain enable.
    logic eoc_o;           // End-of-charge open-drain output value.
    logic eoc_oe;          // End-of-charge open-drain enable.
    logic shutdown_n_line; // Resolved shutdown wire, pulled up.
    logic eoc_n_line;      // Resolved end-of-charge wire, pulled up.

    // Open-drain wires read high unless driven.
    assign shutdown_n_line = sd_oe ? sd_o : 1'b1;
    assign eoc_n_line = eoc_oe ? eoc_o : 1'b1;

    modport dev (
        input addr_seen, wr_valid, wr_addr, wr_data, fets_off_a,
        output int_n, serial_reset, fuse_drive, sd_o, sd_oe, eoc_o, eoc_oe
    );
    modport host (
        output addr_seen, wr_valid, wr_addr, wr_data, fets_off_a,
        input int_n, serial_reset, fuse_drive, shutdown_n_line, eoc_n_line
    );
endinterface

/* rtl/pbw_host.sv */
// Host controller end: APB registers, link writes, pin drive and interrupts.
`timescale 1ns/1ps
`include "pbw_cfg.svh"
module pbw_host
    import pbw_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt.
    output logic irq_o,
    // Link to the device.
    pbw_link_if.host link
);
    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    logic wr_acc, rd_setup, mapped;
    logic [7:0] wr_addr_reg, wr_data_reg;
    logic wr_valid_reg, addr_seen_reg, fets_off_reg;
    logic [`PBW_IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_evt;
    logic int_n_d, sd_n_d, eoc_n_d, fuse_d;

    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign mapped = paddr_i <= `PBW_APB_IRQ_EN && paddr_i[1:0] == 2'h0;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // Link write: address indication with the register write.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_valid_reg <= 1'b0;
            addr_seen_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_valid_reg <= wr_acc && paddr_i == `PBW_APB_LINK_WR;
            addr_seen_reg <= wr_acc && (paddr_i == `PBW_APB_LINK_WR
                || paddr_i == `PBW_APB_PING);
            if (wr_acc && paddr_i == `PBW_APB_LINK_WR) begin
                wr_addr_reg <= pwdata_i[15:8];
                wr_data_reg <= pwdata_i[7:0];
            end
        end
    end

    // Pin control and interrupt enable.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fets_off_reg <= 1'b0;
            irq_en_reg <= '0;
        end else if (wr_acc) begin
            if (paddr_i == `PBW_APB_PIN_CTRL) fets_off_reg <= pwdata_i[0];
            if (paddr_i == `PBW_APB_IRQ_EN) irq_en_reg <= pwdata_i[`PBW_IRQ_W-1:0];
        end
    end

    assign link.wr_valid = wr_valid_reg;
    assign link.addr_seen = addr_seen_reg;
    assign link.wr_addr = wr_addr_reg;
    assign link.wr_data = wr_data_reg;
    assign link.fets_off_a = fets_off_reg;

    // ------------------------------------------------------------------
    // Events and interrupt.
    // ------------------------------------------------------------------
    // Events: interrupt pulse, shutdown, end-of-charge, fuse, serial reset.
    assign irq_evt = {link.serial_reset, link.fuse_drive & ~fuse_d,
        eoc_n_d & ~link.eoc_n_line, sd_n_d & ~link.shutdown_n_line,
        int_n_d & ~link.int_n};

    // Sticky status; a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_stat_reg <= '0;
            int_n_d <= 1'b1;
            sd_n_d <= 1'b1;
            eoc_n_d <= 1'b1;
            fuse_d <= 1'b0;
        end else begin
            int_n_d <= link.int_n;
            sd_n_d <= link.shutdown_n_line;
            eoc_n_d <= link.eoc_n_line;
            fuse_d <= link.fuse_drive;
            if (wr_acc && paddr_i == `PBW_APB_IRQ_CLR) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata_i[`PBW_IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_evt;
            end
        end
    end

    assign irq_o = |(irq_stat_reg & irq_en_reg);

    // Read data captured in the setup cycle.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr_i)
                `PBW_APB_LINK_WR: prdata_o <= {16'h0000, wr_addr_reg, wr_data_reg};
                `PBW_APB_PIN_CTRL: prdata_o <= {31'h0000_0000, fets_off_reg};
                `PBW_APB_STATUS: prdata_o <= {27'h0000_000, link.fuse_drive,
                    link.eoc_n_line, link.shutdown_n_line, link.int_n, fets_off_reg};
                `PBW_APB_IRQ_STAT: prdata_o <= {27'h0000_000, irq_stat_reg};
                `PBW_APB_IRQ_EN: prdata_o <= {27'h0000_000, irq_en_reg};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* dv/pbw_chk.sv */
// Link checks for the pack balance and watchdog pair.
`timescale 1ns/1ps
module pbw_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic addr_seen,
    input wire logic wr_valid,
    input wire logic int_n,
    input wire logic serial_reset,
    input wire logic sd_o,
    input wire logic sd_oe,
    input wire logic eoc_o,
    input wire logic eoc_oe
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // A timeout resets the serial side, then pulls the interrupt low.
    sequence s_trip;
        serial_reset ##1 !int_n;
    endsequence
    a_trip_int_low: assert property (serial_reset |-> s_trip) else $error("no int");
    a_int_pulse_len: assert property (s_trip |-> !int_n[*8]) else $error("int short");
    a_int_rest_high: assert property ($rose(int_n) |-> int_n[*8]) else $error("int gap");
    a_srst_one: assert property (serial_reset |=> !serial_reset) else $error("srst long");
    a_sd_drive_low: assert property (sd_oe |-> !sd_o) else $error("sd high");
    a_eoc_drive_low: assert property (eoc_oe |-> !eoc_o) else $error("eoc high");
    a_ping_one: assert property (addr_seen |=> !addr_seen) else $error("ping long");
    a_wr_one: assert property (wr_valid |=> !wr_valid) else $error("write long");
endmodule

/* dv/pack_balance_watchdog_ctrl_bench.sv */
// Bench for the pack balance and watchdog pair.
`timescale 1ns/1ps
module pack_balance_watchdog_ctrl_bench;
    logic clk_i = 0, sys_rst_i = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, irq, er;
    logic chg = 0, dch = 0, overvoltage_lockout = 0, dif = 0, opw = 0;
    logic [7:0] pa = 8'h00, req = 8'h00, sel, bal;
    logic [31:0] pwd = 32'h0000_0000, rd, prd, seed = 58;
    logic [11:0] cv [8];
    logic [4:0] flt = 5'h00;
    logic [2:0] gate, pd;
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #25 clk_i = ~clk_i;
    pbw_link_if lk ();
    pbw_host pbw_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .irq_o(irq), .link(lk.host));
    pbw_device #(.WDT_TIMEOUT_MS(2), .FET_OFF_CYC(20)) pbw_device_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .link(lk.dev), .charging_current_flag_i(chg),
        .discharging_current_flag_i(dch), .cell_v_i(cv), .cell_balance_req_i(req),
        .pack_fault_i(flt), .overvoltage_lockout_i(overvoltage_lockout), .cell_differential_fault_i(dif),
        .open_wire_i(opw), .balance_out_o(bal), .fet_gate_o(gate), .fet_pulldown_o(pd));
    pbw_chk pbw_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_seen(lk.addr_seen),
        .wr_valid(lk.wr_valid), .int_n(lk.int_n), .serial_reset(lk.serial_reset),
        .sd_o(lk.sd_o), .sd_oe(lk.sd_oe), .eoc_o(lk.eoc_o), .eoc_oe(lk.eoc_oe));
    // Fixed-seed xorshift source for random stimulus.
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected balance enable from direction options and current flags.
    function logic en(input int ic, id, c, d);
        return (ic && c && !d) || (id && d && !c);
    endfunction
    task chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer; request held until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1;
        do @(posedge clk_i); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task lw(input logic [7:0] o, d);
        apb(1, 8'h00, {16'h0000, o, d});
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 70000) begin
            n_errors++;
            print_verdict;
        end
    end
    initial begin
        foreach (cv[i]) cv[i] = 12'h100;
        wt(2);
        sys_rst_i <= 0;
        lw(8'h88, 8'hFF);
        lw(8'h89, 8'h13);
        lw(8'h8C, 8'h00);
        lw(8'h8D, 8'h08);
        req <= 8'(xs());
        wt(60);
        for (int i = 0; i < 16; i++) begin
            lw(8'h86, 8'(i % 4));
            chg <= i[2];
            dch <= i[3];
            wt(6);
            chk(bal, en(i[0], i[1], i[2], i[3]) ? req : 8'h00);
        end
        $display("direction table done");
        lw(8'h86, 8'h04);
        foreach (cv[i]) cv[i] <= 12'hFFF;
        wt(6);
        chk(lk.eoc_n_line, 0);
        chk(bal, req);
        foreach (cv[i]) cv[i] <= 12'h100;
        wt(6);
        chk(lk.eoc_n_line, 1);
        chk(bal, 0);
        chg <= 1;
        dch <= 0;
        lw(8'h86, 8'h19);
        apb(1, 8'h08, 1);
        wt(4);
        chk({gate, bal}, 0);
        chk(pd, 7);
        wt(25);
        chk(pd, 0);
        apb(1, 8'h08, 0);
        wt(6);
        chk(bal, req);
        $display("fets off done");
        apb(1, 8'h18, 2);
        flt <= 5'(xs()) | 5'h01;
        wt(4);
        chk({lk.shutdown_n_line, irq}, 1);
        apb(0, 8'h10, 0);
        chk(rd, 32'h0000_0006);
        flt <= 0;
        wt(4);
        chk(lk.shutdown_n_line, 1);
        apb(1, 8'h14, 2);
        apb(1, 8'h18, 0);
        flt <= 1;
        wt(4);
        chk(irq, 0);
        flt <= 0;
        for (int k = 0; k < 4; k++) begin
            overvoltage_lockout <= k == 1;
            dif <= k == 2;
            opw <= k == 3;
            wt(4);
            chk(lk.fuse_drive, k != 0);
        end
        {overvoltage_lockout, dif, opw} <= 0;
        apb(0, 8'h20, 0);
        chk(er, 1);
        chk(rd, 0);
        $display("pins done");
        sel = 8'(xs());
        lw(8'h84, sel);
        lw(8'h85, 8'h08);
        lw(8'h85, 8'h58);
        wt(4);
        chk(bal, sel);
        chk(gate, 0);
        for (int j = 0; j < 50000 && lk.serial_reset !== 1'b1; j++) @(posedge clk_i);
        chk(lk.serial_reset, 1);
        wt(3);
        chk({gate, bal, lk.int_n}, 0);
        wt(100);
        chk({gate, bal}, 0);
        apb(1, 8'h04, 0);
        wt(6);
        chk(bal, sel);
        chk(gate, 7);
        chk(lk.int_n, 1);
        $display("watchdog done");
        print_verdict;
    end
endmodule
